/* File: core/sda_buf.sv */
// small result buffer with valid and ready on both sides
// assumes the reader may stall for any time; head word always sits in a register
`timescale 1ns/100ps
`default_nettype none
module sda_buf #(
  parameter int W = 28, // word width
  parameter int DEPTH = 2 // entries
) (
  input wire logic sys_clk, // master clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic in_valid, // writer offers a word
  output logic in_ready, // buffer can take a word
  input wire logic [W-1:0] in_data, // offered word
  output logic out_valid, // head word valid
  input wire logic out_ready, // reader takes the head word
  output logic [W-1:0] out_data // head word, registered
);

  localparam int CW = $clog2(DEPTH + 1); // count width

  // buffer state: entries shift toward slot 0
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent; // stored words
    logic [CW-1:0] cnt; // words held
  } sda_buf_state_type;

  sda_buf_state_type s_q; // registered state
  sda_buf_state_type s_d; // next state
  logic push; // word accepted
  logic pop; // word delivered
  logic [CW-1:0] idx; // slot the pushed word lands in

  // full refuses even when a pop happens, so ready never depends on the reader
  assign in_ready = s_q.cnt != CW'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.ent[0];

  // next-state logic
  always_comb begin
    s_d = s_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    idx = s_q.cnt;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_d.ent[i] = s_q.ent[i+1];
      end
      idx = s_q.cnt - CW'(1);
    end
    if (push) begin
      s_d.ent[idx] = in_data;
    end
    s_d.cnt = idx + CW'(push);
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

/* File: core/sda_filter.sv */
// sinc5 decimator, programmable averager and conversion sequencer
// assumes modulator bits synchronous to sys_clk; host pulls results through the buffer
// Notes on behaviour
// - sinc5 stage, decimate 64, word per 128
// - averager count 1, 4, 16, 64 by rate
// - scan period adds overhead and delay, chop doubles
// - fixed period bare unless chop adds overhead
// - delay codes give 0 to 48 slots
// - chop halves the delivered data rate in scan mode; in fixed mode it also adds overhead and delay
// - scan serves channels in turn
// - ready goes low per available result
// - scan results always fully settled
// - first result after start is settled
// - input stable one cycle, five fixed unaveraged
// - sinc5 zeros at clock over 128
// - averaging adds N minus one notches
// - scan changes timing only, not arithmetic
// - one bit selects scan or fixed timing
`timescale 1ns/100ps
`default_nettype none
module sda_filter #(
  parameter int BUF_DEPTH = 2 // result buffer entries
) (
  input wire logic sys_clk, // master clock, 10 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic mod_bit, // modulator bit, 1 means plus full scale
  input wire logic conv_run, // conversions run while high, start on rise
  input wire logic scan_mode_select, // 1 automatic scan, 0 fixed channel
  input wire logic chop_enable, // chop the input in two halves
  input wire logic [1:0] rate_select_field, // average count code
  input wire logic [2:0] switch_delay_field, // settling delay code
  input wire logic [sda_pkg::CH_W-1:0] scan_last_chan, // last channel in the scan loop
  input wire logic result_take, // host takes the current result
  output logic result_ready_n, // low while a result waits
  output sda_pkg::sda_result_type result_word, // result and its channel
  output logic [sda_pkg::CH_W-1:0] mux_chan, // channel the multiplexer should select
  output logic chop_swap // swap input polarity for second half
);

  sda_pkg::sda_filt_state_type s_q; // registered state
  sda_pkg::sda_filt_state_type s_d; // next state
  logic buf_in_ready; // buffer can take the offered word
  logic res_avail; // buffer head valid
  logic run_rise; // conversion start
  logic fin; // a result completes this cycle
  logic filt_on; // filter datapath running
  logic tick; // a first-stage word is due
  logic [sda_pkg::INT_W-1:0] x_in; // modulator bit as plus or minus one
  logic [sda_pkg::INT_W-1:0] cic_out; // first-stage word
  logic [sda_pkg::INT_W-1:0] c; // comb chain temporary
  logic [sda_pkg::SUM_W-1:0] acc_new; // sum including this word
  logic [sda_pkg::SUM_W-1:0] wsum; // sum ready for scaling
  sda_pkg::sda_result_type w; // finished result

  // head of the sequence before a conversion: delay slots, then idle pad
  function automatic sda_pkg::sda_filt_state_type go_delay(
      input sda_pkg::sda_filt_state_type t, input logic [2:0] dl);
    t.st = (dl == 3'h0) ? sda_pkg::ST_PAD : sda_pkg::ST_DELAY;
    t.dec = '0;
    t.unit = '0;
    return t;
  endfunction

  // clear the whole filter and start refilling
  function automatic sda_pkg::sda_filt_state_type go_flush(
      input sda_pkg::sda_filt_state_type t);
    t.st = sda_pkg::ST_FLUSH;
    t.dec = '0;
    t.flush = '0;
    t.integ = '0;
    t.dly = '0;
    return t;
  endfunction

  // fresh conversion: scan and chop pay the overhead, fixed mode only refills
  function automatic sda_pkg::sda_filt_state_type go_next(
      input sda_pkg::sda_filt_state_type t, input logic scan, input logic chop,
      input logic [2:0] dl);
    if (scan || chop) begin
      return go_delay(t, dl);
    end
    return go_flush(t);
  endfunction

  // scale the sum by the count, then saturate into the output word
  function automatic logic [sda_pkg::OUT_W-1:0] scale_word(input logic [sda_pkg::SUM_W-1:0] v,
                                                          input logic [1:0] dr);
    logic signed [sda_pkg::SUM_W-1:0] t;
    t = $signed(v) >>> ({1'b0, sda_pkg::avg_shift(dr)} + sda_pkg::OUT_SHIFT);
    if (t > $signed(sda_pkg::OUT_MAX)) begin
      t = $signed(sda_pkg::OUT_MAX);
    end else if (t < $signed(sda_pkg::OUT_MIN)) begin
      t = $signed(sda_pkg::OUT_MIN);
    end
    return t[sda_pkg::OUT_W-1:0];
  endfunction

  assign filt_on = (s_q.st == sda_pkg::ST_FLUSH) || (s_q.st == sda_pkg::ST_AVG);
  assign tick = filt_on && (s_q.dec == sda_pkg::DEC_LAST);
  assign mux_chan = s_q.chan;
  assign chop_swap = s_q.chop_ph;
  assign result_ready_n = !res_avail;

  // filter datapath and sequencer
  always_comb begin
    s_d = s_q;
    fin = 1'b0;
    c = '0;
    cic_out = '0;
    wsum = '0;
    w = '0;
    x_in = mod_bit ? 32'h0000_0001 : 32'hffff_ffff;
    run_rise = conv_run && !s_q.run;
    s_d.run = conv_run;
    s_d.dec = s_q.dec + 7'h01;
    s_d.gap = s_q.gap + 16'h0001;
    // word leaves toward the buffer
    if (s_q.res_v && buf_in_ready) begin
      s_d.res_v = 1'b0;
    end
    // integrators take a bit every second clock, 64 per word slot
    if (filt_on && s_q.dec[0]) begin
      s_d.integ[0] = s_q.integ[0] + x_in;
      for (int k = 1; k < sda_pkg::SINC_ORDER; k++) begin
        s_d.integ[k] = s_q.integ[k] + s_d.integ[k-1];
      end
    end
    // combs run once per slot; differencing over 64 bits puts zeros at fclk/128
    if (tick) begin
      c = s_d.integ[sda_pkg::SINC_ORDER-1];
      for (int k = 0; k < sda_pkg::SINC_ORDER; k++) begin
        s_d.dly[k] = c;
        c = c - s_q.dly[k];
      end
      cic_out = c;
    end
    // boxcar sum of consecutive words, same arithmetic in both modes
    acc_new = s_q.acc + sda_pkg::SUM_W'($signed(cic_out));
    if (!conv_run) begin
      s_d.st = sda_pkg::ST_IDLE;
      s_d.gap_ok = 1'b0;
    end else if (run_rise) begin
      // a start always refills, so the first result is settled
      s_d.chan = '0;
      s_d.chop_ph = 1'b0;
      s_d.gap_ok = 1'b0;
      s_d = go_next(s_d, scan_mode_select, chop_enable, switch_delay_field);
    end else begin
      case (s_q.st)
        sda_pkg::ST_IDLE: begin
          // wait for the next rise of the run level
        end
        sda_pkg::ST_DELAY: begin
          // settling time for the freshly switched channel
          if (s_q.dec == sda_pkg::DEC_LAST) begin
            s_d.unit = s_q.unit + 6'h01;
            if (s_q.unit + 6'h01 == sda_pkg::dly_units(switch_delay_field)) begin
              s_d.st = sda_pkg::ST_PAD;
              s_d.dec = '0;
            end
          end
        end
        sda_pkg::ST_PAD: begin
          // fractional part of the overhead, then clear and refill
          if (s_q.dec == sda_pkg::PAD_LAST) begin
            s_d = go_flush(s_d);
          end
        end
        sda_pkg::ST_FLUSH: begin
          // partly filled sinc words are dropped, never delivered
          if (tick) begin
            s_d.flush = s_q.flush + 2'h1;
            if (s_q.flush == sda_pkg::FLUSH_LAST) begin
              s_d.st = sda_pkg::ST_AVG;
              s_d.nct = '0;
              s_d.acc = '0;
            end
          end
        end
        sda_pkg::ST_AVG: begin
          if (tick) begin
            if (s_q.nct == sda_pkg::navg(rate_select_field) - 7'h01) begin
              if (chop_enable && !s_q.chop_ph) begin
                // first half kept; second half repeats the sequence swapped
                s_d.half0 = acc_new;
                s_d.chop_ph = 1'b1;
                s_d = go_delay(s_d, switch_delay_field);
              end else begin
                fin = 1'b1;
                s_d.gap = '0;
                s_d.gap_ok = 1'b1;
                // chop difference cancels offset; halving each half first keeps the
                // difference of two full-scale 64-word sums inside the sum width
                wsum = chop_enable ?
                    sda_pkg::SUM_W'(($signed(s_q.half0) >>> 1) - ($signed(acc_new) >>> 1)) :
                    acc_new;
                w.data = scale_word(wsum, rate_select_field);
                w.chan = s_q.chan;
                s_d.chop_ph = 1'b0;
                if (scan_mode_select) begin
                  s_d.chan = (s_q.chan == scan_last_chan) ? '0 : s_q.chan + 4'h1;
                end
                if (s_d.res_v) begin
                  // buffer still busy: park the word, restart later
                  s_d.pend = w;
                  s_d.st = sda_pkg::ST_HOLD;
                  s_d.gap_ok = 1'b0;
                end else begin
                  s_d.res = w;
                  s_d.res_v = 1'b1;
                  if (scan_mode_select || chop_enable) begin
                    s_d = go_delay(s_d, switch_delay_field);
                  end else begin
                    // fixed, unchopped: keep the sinc memory and run on
                    s_d.nct = '0;
                    s_d.acc = '0;
                  end
                end
              end
            end else begin
              s_d.nct = s_q.nct + 7'h01;
              s_d.acc = acc_new;
            end
          end
        end
        sda_pkg::ST_HOLD: begin
          // continuity was lost while stalled, so refill before the next word
          if (!s_q.res_v) begin
            s_d.res = s_q.pend;
            s_d.res_v = 1'b1;
            s_d = go_next(s_d, scan_mode_select, chop_enable, switch_delay_field);
          end
        end
        default: begin
          s_d.st = sda_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= sda_pkg::FILT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // two words of slack so a slow reader loses nothing
  sda_buf #(
    .W($bits(sda_pkg::sda_result_type)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(s_q.res_v),
    .in_ready(buf_in_ready),
    .in_data(s_q.res),
    .out_valid(res_avail),
    .out_ready(result_take),
    .out_data(result_word)
  );

  // checks, all in the master clock domain
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    conv_run && !s_q.run;
  endsequence

  sequence s_refilling;
    (s_q.st != sda_pkg::ST_AVG)[*8];
  endsequence

  AST_SCAN_PERIOD: assert property (
    fin && s_q.gap_ok && scan_mode_select |->
      s_q.gap == 16'(sda_pkg::conv_clocks(1'b1, chop_enable, rate_select_field,
                                           switch_delay_field) - 1))
    else $error("scan word period wrong");

  AST_FIXED_PERIOD: assert property (
    fin && s_q.gap_ok && !scan_mode_select |->
      s_q.gap == 16'(sda_pkg::conv_clocks(1'b0, chop_enable, rate_select_field,
                                           switch_delay_field) - 1))
    else $error("fixed word period wrong");

  AST_CHOP_HALF: assert property (
    fin && s_q.gap_ok && scan_mode_select && chop_enable |->
      s_q.gap + 16'h0001 == 16'(2 * sda_pkg::conv_clocks(1'b1, 1'b0, rate_select_field,
                                                         switch_delay_field)))
    else $error("chop does not halve the rate");

  AST_READY_LOW: assert property (
    s_q.res_v && buf_in_ready |=> !result_ready_n)
    else $error("ready not low after a result");

  AST_SCAN_NEXT: assert property (
    fin && scan_mode_select && conv_run |=>
      s_q.chan == (($past(s_q.chan) == $past(scan_last_chan)) ? '0 : $past(s_q.chan) + 4'h1))
    else $error("scan channel did not advance");

  AST_CLEAR_FILL: assert property (
    s_q.st == sda_pkg::ST_PAD && s_q.dec == sda_pkg::PAD_LAST && conv_run && s_q.run |=>
      s_q.st == sda_pkg::ST_FLUSH && s_q.integ == '0 && s_q.flush == 2'h0)
    else $error("filter not cleared before refill");

  AST_START_SETTLE: assert property (
    s_start |=> s_refilling)
    else $error("averaging began without refill");

  AST_NAVG: assert property (
    tick && s_q.st == sda_pkg::ST_AVG |-> s_q.nct < sda_pkg::navg(rate_select_field))
    else $error("average count exceeded");

  AST_SCAN_SETTLE: assert property (
    fin && scan_mode_select && conv_run |=>
      s_q.st inside {sda_pkg::ST_DELAY, sda_pkg::ST_PAD, sda_pkg::ST_HOLD})
    else $error("scan did not refill after a switch");

endmodule
`default_nettype wire

/* File: core/sda_pkg.sv */
// shared constants, carrier types and helper functions for the sinc decimation averager
// assumes a single master clock domain; modulator bits are offered every second clock
package sda_pkg;

  // first stage: fifth-order sinc, decimation by 64 at half the master clock
  localparam int DEC_FACTOR = 64; // modulator bits per first-stage word
  localparam int DEC_PERIOD = 2 * DEC_FACTOR; // master clocks per first-stage word
  localparam int SINC_ORDER = 5; // integrator and comb sections
  localparam logic [6:0] DEC_LAST = 7'(DEC_PERIOD - 1); // last clock of a word slot

  // overhead of 4.265625 word slots, kept in 1/64 units to stay integer
  localparam int OVH_X64 = 273; // 4.265625 * 64
  localparam int OVH_CLK = OVH_X64 * DEC_PERIOD / DEC_FACTOR; // overhead in master clocks
  localparam int FLUSH_WORDS = SINC_ORDER - 1; // partial words dropped after a clear
  localparam logic [1:0] FLUSH_LAST = 2'(FLUSH_WORDS - 1); // last dropped word index
  localparam logic [6:0] PAD_LAST = 7'(OVH_CLK - FLUSH_WORDS * DEC_PERIOD - 1); // idle pad end

  // datapath widths
  localparam int INT_W = 32; // integrator width, holds 30 bits of growth plus sign
  localparam int SUM_W = 38; // averager sum, six more bits for 64 words
  localparam int OUT_W = 24; // delivered result word
  localparam int CH_W = 4; // channel index width
  localparam logic [3:0] OUT_SHIFT = 4'h7; // sinc gain 2^30 down to a 24-bit word
  localparam logic [SUM_W-1:0] OUT_MAX = 38'h7f_ffff; // largest positive result
  localparam logic [SUM_W-1:0] OUT_MIN = 38'h3f_ff80_0000; // most negative result

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_PAD,
    ST_FLUSH,
    ST_AVG,
    ST_HOLD
  } sda_state_type;

  // one delivered result with the channel it belongs to
  typedef struct packed {
    logic [CH_W-1:0] chan; // channel converted
    logic [OUT_W-1:0] data; // two's complement result
  } sda_result_type;

  // complete state of the filter top
  typedef struct packed {
    sda_state_type st; // sequencer state
    logic [6:0] dec; // clock slot inside a word period
    logic [5:0] unit; // switch delay units elapsed
    logic [1:0] flush; // dropped first-stage words
    logic [6:0] nct; // averaged words so far
    logic chop_ph; // second chop half in progress
    logic [CH_W-1:0] chan; // channel being converted
    logic run; // previous run level, for edge detect
    logic [SINC_ORDER-1:0][INT_W-1:0] integ; // integrator chain
    logic [SINC_ORDER-1:0][INT_W-1:0] dly; // comb delay chain
    logic [SUM_W-1:0] acc; // averager sum
    logic [SUM_W-1:0] half0; // first chop half
    sda_result_type res; // word offered to the buffer
    logic res_v; // offered word valid
    sda_result_type pend; // word parked while buffer is busy
    logic [15:0] gap; // clocks since previous result
    logic gap_ok; // gap spans one undisturbed period
  } sda_filt_state_type;

  localparam sda_filt_state_type FILT_RESET = '0; // idle, everything cleared

  // averages per rate code
  function automatic logic [6:0] navg(input logic [1:0] dr);
    case (dr)
      2'h3: navg = 7'h01;
      2'h2: navg = 7'h04;
      2'h1: navg = 7'h10;
      default: navg = 7'h40;
    endcase
  endfunction

  // log2 of the average count, used to scale the sum
  function automatic logic [2:0] avg_shift(input logic [1:0] dr);
    avg_shift = 3'(2 * (3 - int'(dr)));
  endfunction

  // switch delay in word slots per delay code
  function automatic logic [5:0] dly_units(input logic [2:0] code);
    case (code)
      3'h0: dly_units = 6'h00;
      3'h1: dly_units = 6'h01;
      3'h2: dly_units = 6'h02;
      3'h3: dly_units = 6'h04;
      3'h4: dly_units = 6'h08;
      3'h5: dly_units = 6'h10;
      3'h6: dly_units = 6'h20;
      default: dly_units = 6'h30;
    endcase
  endfunction

  // master clocks per delivered word for a configuration
  function automatic int conv_clocks(input logic scan, input logic chop,
                                     input logic [1:0] dr, input logic [2:0] dl);
    int base;
    base = DEC_PERIOD * int'(navg(dr));
    if (scan || chop) begin
      base = base + DEC_PERIOD * int'(dly_units(dl)) + OVH_CLK;
    end
    conv_clocks = chop ? 2 * base : base;
  endfunction

endpackage

/* File: tb/sda_mod_model.sv */
// modulator stand-in: a constant full-scale bitstream of chosen polarity
// assumes the front end swaps input polarity while chop_swap is high
`timescale 1ns/100ps
`default_nettype none
module sda_mod_model (
  input wire logic sys_clk, // master clock
  input wire logic level, // 1 plus full scale, 0 minus full scale
  input wire logic chop_swap, // second chop half in progress
  output logic mod_bit // bitstream into the filter
);
  // input held steady through a conversion so every word can settle
  initial mod_bit = 1'b0;
  always @(posedge sys_clk) begin
    mod_bit <= level ^ chop_swap; // swapped input flips the bit density
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the sinc decimation averager
// assumes full-scale constant input, so settled words saturate to known values
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TIME_LIMIT = 100000; // clocks, above the planned sequence
  logic sys_clk = 1'b0; // master clock
  logic sys_rst = 1'b1; // reset held at start
  logic conv_run = 1'b0; // run level
  logic scan_mode_select = 1'b0; // scan or fixed
  logic chop_enable = 1'b0; // chop on
  logic [1:0] rate_select_field = 2'h3; // average code
  logic [2:0] switch_delay_field = 3'h0; // delay code
  logic [sda_pkg::CH_W-1:0] scan_last_chan = 4'h0; // scan loop end
  logic result_take = 1'b0; // host pop
  logic level = 1'b1; // partner polarity
  logic mod_bit; // bitstream
  logic result_ready_n; // word waiting, low
  logic chop_swap; // second half
  logic [sda_pkg::CH_W-1:0] mux_chan; // selected channel
  sda_pkg::sda_result_type result_word; // head word
  int err_total = 0; // mismatches
  int samples_checked = 0; // comparisons
  int cyc = 0; // clock count
  logic [31:0] rnd = 32'h3ad3_9d68; // random state

  sda_filter dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mod_bit(mod_bit),
    .conv_run(conv_run), .scan_mode_select(scan_mode_select), .chop_enable(chop_enable),
    .rate_select_field(rate_select_field), .switch_delay_field(switch_delay_field),
    .scan_last_chan(scan_last_chan), .result_take(result_take),
    .result_ready_n(result_ready_n), .result_word(result_word), .mux_chan(mux_chan),
    .chop_swap(chop_swap));
  sda_mod_model modulator (.sys_clk(sys_clk), .level(level), .chop_swap(chop_swap),
    .mod_bit(mod_bit));

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == TIME_LIMIT) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0020_0003 : 32'h0000_0000);
  endfunction

  // clocks between delivered words, kept separate from the design's arithmetic
  function automatic int exp_period(input logic sc, ch, input logic [1:0] dr,
                                    input logic [2:0] dl);
    int u[8] = '{0, 1, 2, 4, 8, 16, 32, 48};
    int base;
    base = 128 << (2 * (3 - int'(dr)));
    if (sc || ch) begin
      base = base + 128 * u[dl] + 546;
    end
    return ch ? 2 * base : base;
  endfunction

  task automatic chk_word(input sda_pkg::sda_result_type got, input sda_pkg::sda_result_type exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle take, then sample settled outputs
  task automatic pop();
    @(posedge sys_clk);
    result_take <= 1'b1;
    @(posedge sys_clk);
    result_take <= 1'b0;
    #10;
  endtask

  // wait for a word under a bound, note when, then take it
  task automatic get_word(output sda_pkg::sda_result_type w, output int t);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #10;
      n++;
    end while (result_ready_n !== 1'b0 && n < 40000);
    chk_flag(result_ready_n, 1'b0);
    t = cyc;
    w = result_word;
    pop();
  endtask

  // stop and configure in the same cycle, wait three clocks, drain, then start
  task automatic start_case(input logic sc, ch, input logic [1:0] dr, input logic [2:0] dl,
                            input logic lv, input logic [3:0] last);
    @(posedge sys_clk);
    conv_run <= 1'b0;
    scan_mode_select <= sc;
    chop_enable <= ch;
    rate_select_field <= dr;
    switch_delay_field <= dl;
    level <= lv;
    scan_last_chan <= last;
    repeat (3) @(posedge sys_clk);
    #10;
    while (result_ready_n === 1'b0) begin
      pop();
    end
    @(posedge sys_clk);
    conv_run <= 1'b1; // rise starts a fresh, cleared conversion
  endtask

  task automatic run_case(input logic sc, ch, input logic [1:0] dr, input logic [2:0] dl,
                          input logic lv, input logic [3:0] last);
    sda_pkg::sda_result_type w0, w1, e0, e1;
    int t0, t1;
    start_case(sc, ch, dr, dl, lv, last);
    get_word(w0, t0);
    get_word(w1, t1);
    e0 = {4'h0, (lv ? 24'h7f_ffff : 24'h80_0000)};
    e1 = e0;
    e1.chan = sc ? 4'(1 % (int'(last) + 1)) : 4'h0;
    chk_word(w0, e0);
    chk_word(w1, e1);
    chk_cnt(t1 - t0, exp_period(sc, ch, dr, dl));
    chk_cnt(mux_chan, sc ? 2 % (int'(last) + 1) : 0);
  endtask

  // host stalls past buffer depth, then drains; aborted run delivers nothing
  task automatic stall_case();
    sda_pkg::sda_result_type w;
    int k;
    start_case(1'b0, 1'b0, 2'h3, 3'h0, 1'b1, 4'h0);
    repeat (1100) @(posedge sys_clk); // four words finish, so one is parked
    #10;
    k = 0;
    while (result_ready_n === 1'b0 && k < 8) begin
      w = result_word;
      chk_word(w, {4'h0, 24'h7f_ffff});
      pop();
      k++;
    end
    chk_flag(k >= 2, 1'b1); // two buffered words survive the stall
    @(posedge sys_clk);
    conv_run <= 1'b0;
    repeat (300) @(posedge sys_clk);
    #10;
    chk_flag(result_ready_n, 1'b1);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence: corners, every delay code, random mixes, stall
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run_case(1'b0, 1'b0, 2'h3, 3'h0, 1'b1, 4'h0);
    run_case(1'b0, 1'b0, 2'h1, 3'h0, 1'b0, 4'h0);
    run_case(1'b1, 1'b0, 2'h0, 3'h0, 1'b1, 4'h1);
    run_case(1'b1, 1'b1, 2'h2, 3'h0, 1'b1, 4'h2);
    run_case(1'b0, 1'b1, 2'h3, 3'h1, 1'b0, 4'h0);
    for (int d = 0; d < 8; d++) begin
      run_case(1'b1, 1'b0, 2'h3, 3'(d), d[0], 4'(d)); // delay table sweep
    end
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr_next(rnd);
      run_case(rnd[0], rnd[1], {1'b1, rnd[2]}, {1'b0, rnd[4:3]}, rnd[5], rnd[9:6]);
    end
    stall_case();
    report_and_stop();
  end
endmodule
`default_nettype wire
